/* hw/ccs_pkg.sv */
// shared constants, register layouts and bus carriers for the clock strap and output control block
package ccs_pkg;

  localparam int CCS_NCH = 11;

  // clock channel indices, one bit per channel in every channel-wide vector
  localparam int CH_HOST = 0;
  localparam int CH_AGP = 1;
  localparam int CH_PERI = 2;
  localparam int CH_PERI_FREE = 3;
  localparam int CH_MEM_A = 4;
  localparam int CH_MEM_B = 5;
  localparam int CH_MEM = 6;
  localparam int CH_REFERENCE_CLOCK_OUT = 7;
  localparam int CH_USB48 = 8;
  localparam int CH_SIO24 = 9;
  localparam int CH_REF1 = 10;

  // channel groups
  localparam logic [CCS_NCH-1:0] CCS_HOST_GRP = 11'h003;
  localparam logic [CCS_NCH-1:0] CCS_PERI_GRP = 11'h004;
  localparam logic [CCS_NCH-1:0] CCS_SYNC_GRP = 11'h007;
  localparam logic [CCS_NCH-1:0] CCS_SHARED = 11'h7bc;
  localparam logic [CCS_NCH-1:0] CCS_MEM_GRP = 11'h070;

  // register byte offsets
  localparam logic [11:0] CCS_OFF_FREQ = 12'h000;
  localparam logic [11:0] CCS_OFF_OUTEN = 12'h004;
  localparam logic [11:0] CCS_OFF_TRI = 12'h008;
  localparam logic [11:0] CCS_OFF_STAT = 12'h00c;

  typedef struct packed {
    logic spread_wide;
    logic [2:0] soft_sel;
    logic sw_select;
    logic soft_sel3;
    logic [1:0] rsvd;
  } ccs_freq_reg_t;

  typedef struct packed {
    logic [2:0] fs;
    logic mode;
    logic mem_src;
    logic host_2v5;
  } ccs_strap_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ccs_apb_rsp_t;

  localparam ccs_freq_reg_t CCS_FREQ_RST = 8'h00;
  localparam logic [CCS_NCH-1:0] CCS_OUTEN_RST = 11'h7ff;
  localparam logic [CCS_NCH-1:0] CCS_TRI_RST = 11'h000;
  localparam ccs_strap_t CCS_STRAP_RST = 6'h04;

  // strap pins are floated this long after reset before capture
  localparam int CCS_CLK_NS = 10;
  localparam int CCS_SETTLE_NS = 200;
  localparam int CCS_SETTLE_CYC = (CCS_SETTLE_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;

  // half periods in ref_clk cycles; the real synthesizer tables are outside this block
  localparam int CCS_HALF_DEF [CCS_NCH] = '{2, 3, 4, 4, 2, 2, 2, 7, 2, 4, 7};

endpackage

/* hw/ccs_ctrl.sv */
// clock strap capture, output enable/tri-state control and stop gating with apb registers
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - at power up capture three frequency straps as the hardware frequency code
// - first peripheral strap pin then drives a free peripheral clock, never stop-gated
// - capture the mode strap, then drive that pin as the 24 MHz output
// - mode 1: shared pin is memory clock; mode 0: active-low host stop input
// - mode 1: second pin is memory clock; mode 0: active-low peripheral stop input
// - capture memory source strap; 1 follows host clock, 0 follows graphics clock
// - extended variant adds a fourth software select bit, giving sixteen host frequencies
// - software enables each output and selects spread depth through registers
// - software can put each output into tri-state or normal driving
// - the strap pin shared with fixed output then drives the 48 MHz clock
// - capture host buffer level strap, then drive the pin as reference clock
// - an output runs only when its enable bit and its stop input both allow
// - stopped clocks are held low and keep full high periods when stopping
// - host/peripheral clocks switch after free peripheral rise then own falling edge
module ccs_ctrl
  import ccs_pkg::*;
#(
  parameter bit EXTENDED = 1'b1, // variant with sixteen host frequencies
  parameter int SETTLE_CYC = CCS_SETTLE_CYC, // float time before strap capture
  parameter int HALF_CYC [CCS_NCH] = CCS_HALF_DEF // per channel half period
) (
  input wire logic ref_clk, // 100 MHz core clock
  input wire logic rst_n, // true power-up reset, active low
  input wire ccs_apb_req_t apb_req, // apb request from system controller
  output ccs_apb_rsp_t apb_rsp, // apb answer
  input wire logic [CCS_NCH-1:0] pin_in, // level seen on each clock pin
  output logic [CCS_NCH-1:0] clk_out, // clock level driven on each pin
  output logic [CCS_NCH-1:0] clk_oe_n, // low while the pin is driven
  output logic [3:0] freq_code, // host frequency selection in force
  output logic spread_wide, // spread depth select
  output logic host_2v5, // captured host buffer level
  output logic mem_follows_host, // memory clocks track host clock
  output logic strap_done // straps captured, pins now clocks
);

  typedef enum logic [0:0] {
    CCS_ST_FLOAT = 1'b0,
    CCS_ST_RUN = 1'b1
  } ccs_state_t;

  ccs_state_t state_r;
  logic [15:0] settle_r;
  ccs_strap_t strap_r;
  ccs_freq_reg_t freq_r;
  logic [CCS_NCH-1:0] outen_r;
  logic [CCS_NCH-1:0] tri_r;
  logic [CCS_NCH-1:0] div_raw_r;
  logic [CCS_NCH-1:0] src_raw;
  logic [CCS_NCH-1:0] src_prev_r;
  logic [CCS_NCH-1:0] want;
  logic [CCS_NCH-1:0] arm_r;
  logic [CCS_NCH-1:0] run_r;
  logic [CCS_NCH-1:0] clk_out_r;
  logic [CCS_NCH-1:0] oe_n_r;
  logic [3:0] freq_code_r;
  logic [31:0] prdata_r;
  logic host_stop_n;
  logic peri_stop_n;
  logic free_rise;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;

  // strap capture: pins stay floated after reset, sampled once on entry to run
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= CCS_ST_FLOAT;
      settle_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        CCS_ST_FLOAT:
        begin
          if (settle_r == 16'(SETTLE_CYC - 1))
          begin
            state_r <= CCS_ST_RUN;
          end
          else
          begin
            settle_r <= settle_r + 16'h0001;
          end
        end
        CCS_ST_RUN:
        begin
          state_r <= CCS_ST_RUN;
        end
        default:
        begin
          state_r <= CCS_ST_FLOAT;
        end
      endcase
    end
  end

  // a later warm reset cannot reach here: rst_n is the power-up reset only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_r <= CCS_STRAP_RST;
    end
    else if (state_r == CCS_ST_FLOAT && settle_r == 16'(SETTLE_CYC - 1))
    begin
      strap_r.fs <= {pin_in[CH_PERI], pin_in[CH_PERI_FREE], pin_in[CH_USB48]};
      strap_r.mode <= pin_in[CH_SIO24];
      strap_r.mem_src <= pin_in[CH_REF1];
      strap_r.host_2v5 <= pin_in[CH_REFERENCE_CLOCK_OUT];
    end
  end

  // apb slave: zero wait states, read data prepared during setup
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign addr_hit = apb_req.paddr == CCS_OFF_FREQ || apb_req.paddr == CCS_OFF_OUTEN ||
                    apb_req.paddr == CCS_OFF_TRI || apb_req.paddr == CCS_OFF_STAT;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_r <= CCS_FREQ_RST;
      outen_r <= CCS_OUTEN_RST;
      tri_r <= CCS_TRI_RST;
    end
    else if (wr_en)
    begin
      case (apb_req.paddr)
        CCS_OFF_FREQ:
        begin
          freq_r <= apb_req.pwdata[7:0];
        end
        CCS_OFF_OUTEN:
        begin
          outen_r <= apb_req.pwdata[CCS_NCH-1:0];
        end
        CCS_OFF_TRI:
        begin
          tri_r <= apb_req.pwdata[CCS_NCH-1:0];
        end
        default:
        begin
          freq_r <= freq_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      case (apb_req.paddr)
        CCS_OFF_FREQ:
        begin
          prdata_r <= {24'h00_0000, freq_r};
        end
        CCS_OFF_OUTEN:
        begin
          prdata_r <= {21'h00_0000, outen_r};
        end
        CCS_OFF_TRI:
        begin
          prdata_r <= {21'h00_0000, tri_r};
        end
        CCS_OFF_STAT:
        begin
          prdata_r <= {21'h00_0000, freq_code_r, strap_r, state_r == CCS_ST_RUN};
        end
        default:
        begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;

  // frequency code: hardware straps unless software selection is switched on
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_code_r <= 4'h0;
    end
    else if (freq_r.sw_select)
    begin
      freq_code_r <= {EXTENDED ? freq_r.soft_sel3 : 1'b0, freq_r.soft_sel};
    end
    else
    begin
      freq_code_r <= {1'b0, strap_r.fs};
    end
  end

  // per channel dividers; memory channels borrow a source instead of their own
  genvar gi;
  generate
    for (gi = 0; gi < CCS_NCH; gi++)
    begin : g_div
      logic [7:0] cnt_r;
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_r <= 8'h00;
          div_raw_r[gi] <= 1'b0;
        end
        else if (state_r == CCS_ST_RUN)
        begin
          if (cnt_r == 8'(HALF_CYC[gi] - 1))
          begin
            cnt_r <= 8'h00;
            div_raw_r[gi] <= ~div_raw_r[gi];
          end
          else
          begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      end
      if (CCS_MEM_GRP[gi])
      begin : g_mem
        assign src_raw[gi] = strap_r.mem_src ? div_raw_r[CH_HOST] : div_raw_r[CH_AGP];
      end
      else
      begin : g_own
        assign src_raw[gi] = div_raw_r[gi];
      end
    end
  endgenerate

  // stop pins only exist in mode 0; otherwise they read as "run"
  assign host_stop_n = strap_r.mode || pin_in[CH_MEM_A];
  assign peri_stop_n = strap_r.mode || pin_in[CH_MEM_B];
  assign free_rise = src_raw[CH_PERI_FREE] && !src_prev_r[CH_PERI_FREE];

  always_comb
  begin
    want = outen_r;
    for (int i = 0; i < CCS_NCH; i++)
    begin
      if (CCS_HOST_GRP[i] && !host_stop_n)
      begin
        want[i] = 1'b0;
      end
      if (CCS_PERI_GRP[i] && !peri_stop_n)
      begin
        want[i] = 1'b0;
      end
    end
  end

  // run state changes only as the source goes low, so no high pulse is ever cut short
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev_r <= '0;
      arm_r <= '0;
      run_r <= '0;
    end
    else
    begin
      src_prev_r <= src_raw;
      for (int i = 0; i < CCS_NCH; i++)
      begin
        if (CCS_SYNC_GRP[i])
        begin
          if (free_rise)
          begin
            arm_r[i] <= want[i];
          end
          if (src_prev_r[i] && !src_raw[i])
          begin
            run_r[i] <= arm_r[i];
          end
        end
        else if (src_prev_r[i] && !src_raw[i])
        begin
          run_r[i] <= want[i];
        end
      end
    end
  end

  // pins: shared pins floated before capture, stop-input pins stay floated in mode 0
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_out_r <= '0;
      oe_n_r <= '1;
    end
    else
    begin
      for (int i = 0; i < CCS_NCH; i++)
      begin
        clk_out_r[i] <= src_raw[i] && run_r[i];
        if (state_r != CCS_ST_RUN && CCS_SHARED[i])
        begin
          oe_n_r[i] <= 1'b1;
        end
        else if ((i == CH_MEM_A || i == CH_MEM_B) && !strap_r.mode)
        begin
          oe_n_r[i] <= 1'b1;
        end
        else
        begin
          oe_n_r[i] <= tri_r[i];
        end
      end
    end
  end

  assign clk_out = clk_out_r;
  assign clk_oe_n = oe_n_r;
  assign freq_code = freq_code_r;
  assign spread_wide = freq_r.spread_wide;
  assign host_2v5 = strap_r.host_2v5;
  assign mem_follows_host = strap_r.mem_src;
  assign strap_done = state_r == CCS_ST_RUN;

endmodule

`default_nettype wire

/* bench/ccs_ctrl_checker.sv */
// assertion checker for the clock strap and output control block
`timescale 1ns/10ps
`default_nettype none
module ccs_ctrl_checker
  import ccs_pkg::*;
#(
  parameter int SETTLE_CYC = CCS_SETTLE_CYC // float time before capture
) (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // power-up reset
  input wire ccs_apb_req_t apb_req, // apb request
  input wire ccs_apb_rsp_t apb_rsp, // apb answer
  input wire logic [CCS_NCH-1:0] pin_in, // pin levels
  input wire logic [CCS_NCH-1:0] clk_out, // clock levels
  input wire logic [CCS_NCH-1:0] clk_oe_n, // pin drive enables
  input wire logic [3:0] freq_code, // frequency code
  input wire logic spread_wide, // spread depth
  input wire logic host_2v5, // buffer level
  input wire logic mem_follows_host, // memory source
  input wire logic strap_done // capture done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] up_r;
  logic [5:0] hstop_r;
  logic [5:0] pstop_r;
  // stop counters run only while a memory pin is floated and held low after capture
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      up_r <= '0;
    else if (up_r != 8'hff)
      up_r <= up_r + 8'h01;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      hstop_r <= '0;
    else if (!(strap_done && clk_oe_n[CH_MEM_A] && !pin_in[CH_MEM_A]))
      hstop_r <= '0;
    else if (hstop_r != 6'h3f)
      hstop_r <= hstop_r + 6'h01;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      pstop_r <= '0;
    else if (!(strap_done && clk_oe_n[CH_MEM_B] && !pin_in[CH_MEM_B]))
      pstop_r <= '0;
    else if (pstop_r != 6'h3f)
      pstop_r <= pstop_r + 6'h01;
  sequence s_capture;
    $rose(strap_done);
  endsequence
  a_settle_count: assert property (s_capture |-> up_r == 8'(SETTLE_CYC))
    else $error("strap capture off the settle count");
  a_strap_capture: assert property (s_capture |-> host_2v5 == $past(pin_in[CH_REFERENCE_CLOCK_OUT])
    && mem_follows_host == $past(pin_in[CH_REF1])) else $error("strap levels not captured");
  a_freq_strap: assert property (s_capture |=> freq_code == {1'b0, $past(pin_in[CH_PERI], 2),
    $past(pin_in[CH_PERI_FREE], 2), $past(pin_in[CH_USB48], 2)}) else $error("bad hardware code");
  a_straps_held: assert property (strap_done && $past(strap_done) |-> $stable(host_2v5)
    && $stable(mem_follows_host)) else $error("captured strap changed");
  a_float_until: assert property (!strap_done |-> (clk_oe_n & CCS_SHARED) == CCS_SHARED)
    else $error("shared pin driven before capture");
  a_host_stop: assert property (hstop_r >= 6'd24 |-> (clk_out & CCS_HOST_GRP) == '0)
    else $error("host clocks run while stopped");
  a_periph_stop: assert property (pstop_r >= 6'd24 |-> !clk_out[CH_PERI])
    else $error("peripheral clock runs while stopped");
  a_free_periph: assert property (pstop_r >= 6'd24 |-> ##[1:9] $changed(clk_out[CH_PERI_FREE]))
    else $error("free peripheral clock gated");
  a_host_high: assert property ($rose(clk_out[CH_HOST]) |-> clk_out[CH_HOST] [*2])
    else $error("host high period cut short");
  a_periph_high: assert property ($rose(clk_out[CH_PERI]) |-> clk_out[CH_PERI] [*4])
    else $error("peripheral high period cut short");
  a_slverr_map: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pslverr ==
    (apb_req.paddr[11:4] != 8'h00 || apb_req.paddr[1:0] != 2'b00)) else $error("bad slverr");
endmodule
`default_nettype wire

/* bench/ccs_pins_model.sv */
// board model of the clock pins: strap resistors, stop requests and clock loads
`timescale 1ns/10ps
`default_nettype none
module ccs_pins_model
  import ccs_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic [CCS_NCH-1:0] clk_out, // driven clock levels
  input wire logic [CCS_NCH-1:0] clk_oe_n, // low while the block drives
  input wire ccs_strap_t strap, // strap resistor levels
  input wire logic host_stop_n, // host stop request
  input wire logic periph_stop_n, // peripheral stop request
  output logic [CCS_NCH-1:0] pin_in // resolved pin levels
);
  logic [CCS_NCH-1:0] wander_r = '0;
  logic [CCS_NCH-1:0] ext;
  // undriven pins without a resistor toggle so no stale level looks valid
  always_ff @(posedge ref_clk)
    wander_r <= ~wander_r;
  always_comb
  begin
    ext = wander_r;
    ext[CH_USB48] = strap.fs[0];
    ext[CH_PERI_FREE] = strap.fs[1];
    ext[CH_PERI] = strap.fs[2];
    ext[CH_SIO24] = strap.mode;
    ext[CH_REF1] = strap.mem_src;
    ext[CH_REFERENCE_CLOCK_OUT] = strap.host_2v5;
    ext[CH_MEM_A] = host_stop_n;
    ext[CH_MEM_B] = periph_stop_n;
    pin_in = (clk_out & ~clk_oe_n) | (ext & clk_oe_n);
  end
endmodule
`default_nettype wire

/* bench/ccs_ctrl_tb.sv */
// self-checking bench for the clock strap and output control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g), (g) === (e))
module ccs_ctrl_tb
  import ccs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  ccs_apb_req_t apb_req = '0;
  ccs_apb_rsp_t apb_rsp;
  logic [CCS_NCH-1:0] pin_in, clk_out, clk_oe_n, hi, en;
  logic [3:0] freq_code;
  logic spread_wide, host_2v5, mem_follows_host, strap_done, err;
  ccs_strap_t strap = CCS_STRAP_RST;
  ccs_strap_t s;
  logic host_stop_n = 1'b1;
  logic periph_stop_n = 1'b1;
  logic [31:0] rd;
  logic [7:0] f;
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 32'hf9420316;
  always #5 ref_clk = ~ref_clk;
  ccs_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_in(pin_in), .clk_out(clk_out), .clk_oe_n(clk_oe_n), .freq_code(freq_code),
    .spread_wide(spread_wide), .host_2v5(host_2v5), .mem_follows_host(mem_follows_host),
    .strap_done(strap_done));
  ccs_pins_model u_pins (.ref_clk(ref_clk), .clk_out(clk_out), .clk_oe_n(clk_oe_n),
    .strap(strap), .host_stop_n(host_stop_n), .periph_stop_n(periph_stop_n), .pin_in(pin_in));
  function automatic logic [31:0] stat_exp(ccs_strap_t v);
    return {21'h0, 1'b0, v.fs, v.fs, v.mode, v.mem_src, v.host_2v5, 1'b1};
  endfunction
  task automatic check(string nm, logic [31:0] e, logic [31:0] g, bit ok);
    n_tests++;
    if (!ok)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits for pready as long as it takes; only the watchdog ends a hung transfer
  task automatic apb(bit wr, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic power_up(ccs_strap_t v);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    strap <= v;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge ref_clk);
  endtask
  // settle first, then collect which channels went high during the window
  task automatic watch();
    repeat (30) @(posedge ref_clk);
    hi = '0;
    repeat (40) @(negedge ref_clk) hi |= clk_out;
    // hand back on a rising edge so the next input change lands there
    @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    s = 6'($random(seed));
    s.mode = 1'b1;
    power_up(s);
    apb(0, CCS_OFF_STAT, 32'h0);
    `CHK("stat", stat_exp(s), rd);
    `CHK("levels", {s.host_2v5, s.mem_src}, {host_2v5, mem_follows_host});
    apb(0, CCS_OFF_FREQ, 32'h0);
    `CHK("freq_rst", 32'h0, rd);
    apb(0, CCS_OFF_OUTEN, 32'h0);
    `CHK("outen_rst", 32'h7ff, rd);
    apb(0, CCS_OFF_TRI, 32'h0);
    `CHK("tri_rst", 32'h0, rd);
    apb(1, CCS_OFF_STAT, 32'hffff_ffff);
    apb(0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd});
    apb(0, CCS_OFF_STAT, 32'h0);
    `CHK("stat_ro", stat_exp(s), rd);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      f = {i[0], i[2:0], 1'b1, i[3], 2'b00};
      apb(1, CCS_OFF_FREQ, {24'h0, f});
      repeat (2) @(posedge ref_clk);
      `CHK("soft_code", {i[0], i[3:0]}, {spread_wide, freq_code});
    end
    apb(1, CCS_OFF_FREQ, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK("hw_code", {1'b0, s.fs}, freq_code);
    $display("test frequency done");
    for (int k = 0; k < 5; k++)
    begin
      en = (k == 0) ? '0 : (k == 4) ? '1 : 11'($random(seed));
      apb(1, CCS_OFF_OUTEN, 32'(en));
      watch();
      `CHK("enables", en, hi);
      apb(1, CCS_OFF_TRI, 32'(~en));
      repeat (3) @(posedge ref_clk);
      `CHK("tristate", ~en, clk_oe_n);
    end
    apb(1, CCS_OFF_TRI, 32'h0);
    $display("test outputs done");
    s = 6'($random(seed));
    s.mode = 1'b0;
    power_up(s);
    `CHK("stop_pins", 2'b11, clk_oe_n[CH_MEM_B:CH_MEM_A]);
    host_stop_n <= 1'b0;
    watch();
    `CHK("host_stop", 4'b1100, hi[3:0]);
    host_stop_n <= 1'b1;
    periph_stop_n <= 1'b0;
    watch();
    `CHK("periph_stop", 4'b1011, hi[3:0]);
    periph_stop_n <= 1'b1;
    watch();
    `CHK("resume", 4'b1111, hi[3:0]);
    $display("test stop inputs done");
    conclude();
  end
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule
bind ccs_ctrl ccs_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in), .clk_out(clk_out),
  .clk_oe_n(clk_oe_n), .freq_code(freq_code), .spread_wide(spread_wide), .host_2v5(host_2v5),
  .mem_follows_host(mem_follows_host), .strap_done(strap_done));
`default_nettype wire
